/* File: clk_if.sv */
// Purpose: Carries clock tick strobes into the switch sequencer.
// Assumes: Ticks are one-cycle pulses on the core clock.
// Notes:   One modport per side.
`timescale 1ns/1ps
interface clk_if;
  logic old_tick;  // Tick of the outgoing source
  logic new_tick;  // Tick of the incoming source
  logic start;     // Begin a switch
  logic extra;     // Take the fourth new-source cycle
  logic busy;      // Clock held
  logic done;      // Switch completed, one cycle
  modport ctrl (output old_tick, new_tick, start, extra, input busy, done);
  modport seq  (input old_tick, new_tick, start, extra, output busy, done);
endinterface

/* File: clk_source_switch.sv */
// Purpose: Device clock source selection with glitch-free switching.
// Assumes: Oscillator ticks and status pins are asynchronous levels.
// Notes:   Registers reached over APB; unmapped reads give zero.
//
// Decided for this implementation: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
module clk_source_switch
  import clk_switch_pkg::*;
#(
  parameter int unsigned CFG_W = 4  // Primary configuration width
)(
  input  wire logic             i_core_clk,
  input  wire logic             i_sys_rst,
  // APB slave
  input  wire logic             i_psel,
  input  wire logic             i_penable,
  input  wire logic             i_pwrite,
  input  wire logic [7:0]       i_paddr,
  input  wire logic [31:0]      i_pwdata,
  output logic                  o_pready,
  output logic                  o_pslverr,
  output logic [31:0]           o_prdata,
  // Oscillator side, asynchronous
  input  wire logic             i_pri_tick,
  input  wire logic             i_sec_tick,
  input  wire logic             i_int_tick,
  input  wire logic             i_startup_done,
  input  wire logic             i_fast_osc_stable,
  input  wire logic [CFG_W-1:0] i_pri_osc_config,
  input  wire logic             i_pri_is_internal,
  input  wire logic             i_sleep_exec,
  // Clock control outputs
  output logic [2:0]            o_src_sel,
  output logic                  o_clk_hold,
  output logic [2:0]            o_int_freq_sel,
  output logic                  o_lf_from_fast,
  output logic                  o_fast_osc_en,
  output logic                  o_slow_rc_en,
  output logic                  o_multiplier_en,
  output logic [CFG_W-1:0]      o_pri_mode,
  output logic                  o_sec_osc_en,
  output logic                  o_idle_mode,
  output logic                  o_sleep_mode
);
  if (CFG_W != 4) begin : g_cfg_w_check
    $error("CFG_W must be 4");
  end

  // Two-flop synchronisers for every pin input
  localparam int unsigned NS = 8 + CFG_W;
  logic [NS-1:0] pin_raw;
  logic [NS-1:0] sync1_q;   // First stage, read only by second stage
  logic [NS-1:0] sync2_q;
  assign pin_raw = {i_pri_tick, i_sec_tick, i_int_tick, i_startup_done,
                    i_fast_osc_stable, i_pri_is_internal, i_sleep_exec,
                    1'b0, i_pri_osc_config};

  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= pin_raw;
      sync2_q <= sync1_q;
    end
  end

  wire             pri_tick_s  = sync2_q[NS-1];
  wire             sec_tick_s  = sync2_q[NS-2];
  wire             int_tick_s  = sync2_q[NS-3];
  wire             startup_s   = sync2_q[NS-4];
  wire             stable_s    = sync2_q[NS-5];
  wire             pri_int_s   = sync2_q[NS-6];
  wire             sleep_s     = sync2_q[NS-7];
  wire [CFG_W-1:0] cfg_s       = sync2_q[CFG_W-1:0];

  // Sleep pin is a level; act on its rising edge only
  logic sleep_prev_q;
  wire  sleep_evt = sleep_s && !sleep_prev_q;

  // Software-visible control
  logic       idle_en_q;       // idle_on_sleep_enable
  logic [2:0] internal_freq_select_q;          // internal_freq_select
  logic [1:0] scs_q;           // system_clock_select
  logic       lf_src_q;        // low_freq_source_select
  logic       mult_req_q;      // multiplier_enable request
  logic [4:0] tune_q;          // Tuning value, stored only
  logic       sec_en_q;        // secondary_osc_enable
  logic [5:0] tmr_other_q;     // Other timer control bits, stored only

  // APB decode
  wire apb_acc = i_psel && i_penable;
  wire apb_wr  = apb_acc && i_pwrite;
  wire hit_ctl = (i_paddr == OFS_OSC_CTRL);
  wire hit_tun = (i_paddr == OFS_OSC_TUNE);
  wire hit_tmr = (i_paddr == OFS_TIMER_CTRL);
  wire hit_act = (i_paddr == OFS_ACTIVE);
  wire mapped  = hit_ctl || hit_tun || hit_tmr || hit_act;

  // Source and switch tracking
  src_t active_q;              // Source now driving the device clock
  src_t target_q;              // Source being switched to
  logic switching_q;
  src_t want_src;
  assign want_src = decode_scs(scs_q);

  // Tick of a given source
  function automatic logic tick_of(input src_t s, input logic p,
                                   input logic sc, input logic it);
    unique case (s)
      SRC_PRI: return p;
      SRC_SEC: return sc;
      SRC_INT: return it;
      default: return 1'b0;
    endcase
  endfunction

  clk_if sw();
  assign sw.old_tick = tick_of(active_q, pri_tick_s, sec_tick_s, int_tick_s);
  assign sw.new_tick = tick_of(target_q, pri_tick_s, sec_tick_s, int_tick_s);
  // Start as soon as the selection differs from the running source
  assign sw.start    = !switching_q && !sw.busy && (want_src != active_q);
  assign sw.extra    = 1'b0; // Three new cycles, low end of the range

  clk_switch_seq u_seq (
    .i_core_clk (i_core_clk),
    .i_sys_rst  (i_sys_rst),
    .sw         (sw)
  );

  // Register writes; reset defaults
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      idle_en_q   <= 1'b0;
      internal_freq_select_q      <= INTERNAL_FREQ_SELECT_RESET;
      scs_q       <= SCS_RESET;
      lf_src_q    <= 1'b0;
      mult_req_q  <= 1'b0;
      tune_q      <= TUNE_RESET;
      sec_en_q    <= 1'b0;
      tmr_other_q <= 6'h00;
    end else if (apb_wr) begin
      if (hit_ctl) begin
        // Status bits are not writable
        idle_en_q <= i_pwdata[BIT_IDLE_EN];
        internal_freq_select_q    <= i_pwdata[BIT_INTERNAL_FREQ_SELECT_LO +: 3];
        scs_q     <= i_pwdata[BIT_SCS_LO +: 2];
      end
      if (hit_tun) begin
        lf_src_q   <= i_pwdata[BIT_LF_SRC];
        mult_req_q <= i_pwdata[BIT_MULT_EN];
        tune_q     <= i_pwdata[4:0];
      end
      if (hit_tmr) begin
        sec_en_q    <= i_pwdata[BIT_SEC_EN];
        tmr_other_q <= {i_pwdata[7], i_pwdata[5:4], i_pwdata[2:0]};
      end
    end
  end

  // Switch bookkeeping; active source changes only after the hold
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      active_q    <= SRC_PRI;
      target_q    <= SRC_PRI;
      switching_q <= 1'b0;
    end else if (sw.start) begin
      target_q    <= want_src;
      switching_q <= 1'b1;
    end else if (sw.done) begin
      active_q    <= target_q;
      switching_q <= 1'b0;
    end
  end

  // Sleep instruction handling
  logic idle_q;
  logic sleep_q;
  // Secondary selected with its oscillator off: the sleep is ignored
  wire  sleep_blocked = (want_src == SRC_SEC) && !sec_en_q;

  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      sleep_prev_q <= 1'b0;
      idle_q       <= 1'b0;
      sleep_q      <= 1'b0;
    end else begin
      sleep_prev_q <= sleep_s;
      if (sleep_evt && !sleep_blocked) begin
        idle_q  <= idle_en_q;
        sleep_q <= !idle_en_q;
      end else if (!sleep_s) begin
        // Wake when the instruction level drops
        idle_q  <= 1'b0;
        sleep_q <= 1'b0;
      end
    end
  end

  // Status terms; one-hot active source keeps them exclusive
  wire steady  = !switching_q;
  wire startup_timeout_status    = steady && (active_q == SRC_PRI) && startup_s;
  wire internal_freq_stable    = steady && (active_q == SRC_INT) && stable_s &&
                 !(internal_freq_select_q == INTERNAL_FREQ_SELECT_31KHZ && !lf_src_q);
  wire sec_run = steady && (active_q == SRC_SEC);

  // Internal block enables
  wire fast_en = (internal_freq_select_q != INTERNAL_FREQ_SELECT_31KHZ) || lf_src_q;
  wire mult_ok = pri_int_s &&
                 (internal_freq_select_q == INTERNAL_FREQ_SELECT_8MHZ || internal_freq_select_q == INTERNAL_FREQ_SELECT_4MHZ);
  wire mult_rd = mult_req_q && mult_ok;

  // Read mux
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit_ctl) begin
      rd_mux[BIT_IDLE_EN]       = idle_en_q;
      rd_mux[BIT_INTERNAL_FREQ_SELECT_LO +: 3]  = internal_freq_select_q;
      rd_mux[BIT_STARTUP_TIMEOUT_STATUS]          = startup_timeout_status;
      rd_mux[BIT_INTERNAL_FREQ_STABLE]          = internal_freq_stable;
      rd_mux[BIT_SCS_LO +: 2]   = scs_q;
    end else if (hit_tun) begin
      rd_mux[BIT_LF_SRC]  = lf_src_q;
      rd_mux[BIT_MULT_EN] = mult_rd;
      rd_mux[4:0]         = tune_q;
    end else if (hit_tmr) begin
      rd_mux[7:0] = {tmr_other_q[5], sec_run, tmr_other_q[4:3],
                     sec_en_q, tmr_other_q[2:0]};
    end else if (hit_act) begin
      rd_mux[2:0] = active_q;
      rd_mux[3]   = switching_q;
    end
  end

  // APB answer: zero wait states, error on unmapped address
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata  <= 32'h0000_0000;
    end else begin
      o_pready  <= i_psel && !i_penable;
      o_pslverr <= i_psel && !i_penable && !mapped;
      o_prdata  <= (i_psel && !i_penable && !i_pwrite) ? rd_mux
                                                        : 32'h0000_0000;
    end
  end

  // Registered clock control outputs
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_src_sel       <= SRC_PRI;
      o_clk_hold      <= 1'b0;
      o_int_freq_sel  <= INTERNAL_FREQ_SELECT_RESET;
      o_lf_from_fast  <= 1'b0;
      o_fast_osc_en   <= 1'b1;
      o_slow_rc_en    <= 1'b1;
      o_multiplier_en <= 1'b0;
      o_pri_mode      <= '0;
      o_sec_osc_en    <= 1'b0;
      o_idle_mode     <= 1'b0;
      o_sleep_mode    <= 1'b0;
    end else begin
      // New source shows as the hold drops, never after it
      o_src_sel       <= sw.done ? target_q : active_q;
      o_clk_hold      <= sw.busy || sw.start;
      o_int_freq_sel  <= internal_freq_select_q;
      o_lf_from_fast  <= (internal_freq_select_q == INTERNAL_FREQ_SELECT_31KHZ) && lf_src_q;
      o_fast_osc_en   <= fast_en;
      // Slow RC stays on for watchdog and monitor in all modes
      o_slow_rc_en    <= 1'b1;
      o_multiplier_en <= mult_rd;
      o_pri_mode      <= cfg_s;
      // Enable bit alone governs it, so it runs through low power
      o_sec_osc_en    <= sec_en_q;
      o_idle_mode     <= idle_q;
      o_sleep_mode    <= sleep_q;
    end
  end
endmodule // clk_source_switch

/* File: clk_source_switch_bench.sv */
// Purpose: Self-checking bench for the clock source switch.
// Assumes: Wait-free APB slave; all source ticks every fourth cycle.
// Notes:   Stability and start-up inputs are held ready throughout.
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("unexpected %s exp %h got %h", n, e, g); end end
module clk_source_switch_bench;
  import clk_switch_pkg::*;
  logic        clk, rst, psel, penable, pwrite, tk, slp_in;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic        pready, pslverr, hold, lf, fast_en, slow_en, mult;
  logic        sec_en, idle, sleep_m;
  logic [2:0]  src, freq;
  logic [3:0]  pmode;
  logic [1:0]  tcnt;      // Tick phase
  int          error_cnt; // Mismatches
  int          checks;    // Comparisons
  clk_source_switch clk_source_switch_inst (
    .i_core_clk(clk), .i_sys_rst(rst), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_pready(pready), .o_pslverr(pslverr), .o_prdata(prdata),
    .i_pri_tick(tk), .i_sec_tick(tk), .i_int_tick(tk),
    .i_startup_done(1'b1), .i_fast_osc_stable(1'b1),
    .i_pri_osc_config(4'h9), .i_pri_is_internal(1'b1),
    .i_sleep_exec(slp_in), .o_src_sel(src), .o_clk_hold(hold),
    .o_int_freq_sel(freq), .o_lf_from_fast(lf), .o_fast_osc_en(fast_en),
    .o_slow_rc_en(slow_en), .o_multiplier_en(mult), .o_pri_mode(pmode),
    .o_sec_osc_en(sec_en), .o_idle_mode(idle), .o_sleep_mode(sleep_m));
  // Clock at 125 MHz
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // One-cycle ticks with gaps, so each counts once through the sync flops
  always @(posedge clk) begin
    tcnt <= tcnt + 2'h1;
    tk <= (tcnt == 2'h0);
  end
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
  endtask
  // One APB transfer, held until ready is sampled high
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    // Wait for ready however long it takes; only the hang guard ends it
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    `CHK("waits", 1, n);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, {24'h0, d}, r, e);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] x,
                    input logic xe);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    `CHK("prdata", {24'h0, x}, r);
    `CHK("pslverr", xe, e);
  endtask
  // Bounded wait for a source switch to start and finish
  task automatic sw_wait;
    int n;
    n = 0;
    while (hold !== 1'b1 && n < 50) begin
      @(posedge clk);
      n++;
    end
    `CHK("hold_rise", 1'b1, hold);
    while (hold !== 1'b0 && n < 300) begin
      @(posedge clk);
      n++;
    end
    `CHK("hold_fall", 1'b0, hold);
    cyc(2);
  endtask
  // Sleep instruction; latency covers two sync flops, the mode flop and the output flop
  task automatic slp(input logic xi, input logic xs);
    slp_in <= 1'b1;
    cyc(6);
    `CHK("idle", xi, idle);
    `CHK("sleep", xs, sleep_m);
    slp_in <= 1'b0;
    cyc(6);
  endtask
  task automatic report_and_stop;
    $display("error_cnt %0d checks %0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Hang guard, far beyond the few hundred cycles of the run
  initial begin
    #(8 * 20000);
    error_cnt++;
    report_and_stop;
  end
  initial begin
    {rst, psel, penable, pwrite, slp_in} <= 5'h10;
    {paddr, pwdata, tcnt, error_cnt, checks} = '0;
    cyc(2);
    rst <= 1'b0;
    cyc(4);
    rd(OFS_OSC_CTRL, 8'h48, 1'b0);
    rd(OFS_OSC_TUNE, 8'h00, 1'b0);
    wr(OFS_OSC_CTRL, 8'h44);
    rd(OFS_OSC_CTRL, 8'h48, 1'b0);
    rd(8'h10, 8'h00, 1'b1);
    `CHK("pri_mode", 4'h9, pmode);
    wr(OFS_OSC_CTRL, 8'h42);
    sw_wait;
    `CHK("src", 3'b100, src);
    rd(OFS_ACTIVE, 8'h04, 1'b0);
    // Every frequency code while the internal block runs the device
    for (int c = 0; c < 8; c++) begin
      wr(OFS_OSC_CTRL, {1'b0, 3'(c), 2'h0, 1'b1, c[0]});
      cyc(2);
      `CHK("freq", 3'(c), freq);
      `CHK("fast_en", c != 0, fast_en);
      rd(OFS_OSC_CTRL, {1'b0, 3'(c), 1'b0, c != 0, 1'b1, c[0]},
         1'b0);
    end
    wr(OFS_OSC_TUNE, 8'hc0);
    wr(OFS_OSC_CTRL, 8'h02);
    cyc(2);
    `CHK("lf", 1'b1, lf);
    `CHK("fast_en", 1'b1, fast_en);
    wr(OFS_OSC_CTRL, 8'h72);
    cyc(2);
    `CHK("mult", 1'b1, mult);
    wr(OFS_OSC_CTRL, 8'h52);
    cyc(2);
    `CHK("mult", 1'b0, mult);
    `CHK("lf", 1'b0, lf);
    wr(OFS_OSC_TUNE, 8'h00);
    wr(OFS_TIMER_CTRL, 8'h08);
    cyc(2);
    `CHK("sec_en", 1'b1, sec_en);
    wr(OFS_OSC_CTRL, 8'h01);
    sw_wait;
    `CHK("src", 3'b010, src);
    rd(OFS_TIMER_CTRL, 8'h48, 1'b0);
    rd(OFS_OSC_CTRL, 8'h01, 1'b0);
    wr(OFS_TIMER_CTRL, 8'h00);
    wr(OFS_OSC_CTRL, 8'h81);
    slp(1'b0, 1'b0);
    wr(OFS_OSC_CTRL, 8'h80);
    sw_wait;
    `CHK("src", 3'b001, src);
    rd(OFS_OSC_CTRL, 8'h88, 1'b0);
    slp(1'b1, 1'b0);
    wr(OFS_OSC_CTRL, 8'h00);
    slp(1'b0, 1'b1);
    `CHK("slow_rc", 1'b1, slow_en);
    // Reset in the middle of a switch
    wr(OFS_OSC_CTRL, 8'h72);
    cyc(3);
    rst <= 1'b1;
    cyc(2);
    rst <= 1'b0;
    cyc(4);
    rd(OFS_OSC_CTRL, 8'h48, 1'b0);
    `CHK("src", 3'b001, src);
    report_and_stop;
  end
endmodule // clk_source_switch_bench
bind clk_source_switch clk_source_switch_properties
  clk_source_switch_properties_inst (
  .i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .i_psel(i_psel),
  .i_penable(i_penable), .o_pready(o_pready), .o_pslverr(o_pslverr),
  .o_src_sel(o_src_sel), .o_clk_hold(o_clk_hold),
  .o_int_freq_sel(o_int_freq_sel), .o_lf_from_fast(o_lf_from_fast),
  .o_fast_osc_en(o_fast_osc_en), .o_slow_rc_en(o_slow_rc_en),
  .o_multiplier_en(o_multiplier_en), .o_idle_mode(o_idle_mode),
  .o_sleep_mode(o_sleep_mode));

/* File: clk_source_switch_properties.sv */
// Purpose: Concurrent checks on the clock source switch ports.
// Assumes: One core clock domain, reset active high.
// Notes:   Attached by bind from the bench top file.
`timescale 1ns/1ps
module clk_source_switch_properties (
  input wire logic       i_core_clk,
  input wire logic       i_sys_rst,
  input wire logic       i_psel,
  input wire logic       i_penable,
  input wire logic       o_pready,
  input wire logic       o_pslverr,
  input wire logic [2:0] o_src_sel,
  input wire logic       o_clk_hold,
  input wire logic [2:0] o_int_freq_sel,
  input wire logic       o_lf_from_fast,
  input wire logic       o_fast_osc_en,
  input wire logic       o_slow_rc_en,
  input wire logic       o_multiplier_en,
  input wire logic       o_idle_mode,
  input wire logic       o_sleep_mode
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_sys_rst);
  // Shortest pause: two old plus three new ticks, one cycle each at least
  sequence s_hold_run;
    o_clk_hold [*5];
  endsequence
  // Setup cycle of an access
  sequence s_setup;
    i_psel && !i_penable;
  endsequence
  property p_slow_rc_on; o_slow_rc_en; endproperty
  a_slow_rc_on: assert property (p_slow_rc_on)
    else $error("slow rc enable dropped");
  property p_one_src; $onehot(o_src_sel); endproperty
  a_one_src: assert property (p_one_src)
    else $error("source select not one-hot");
  property p_src_in_hold; $changed(o_src_sel) |-> $past(o_clk_hold); endproperty
  a_src_in_hold: assert property (p_src_in_hold)
    else $error("source changed outside a held switch");
  property p_hold_len; $rose(o_clk_hold) |-> s_hold_run; endproperty
  a_hold_len: assert property (p_hold_len)
    else $error("clock hold shorter than five cycles");
  property p_lf_code; o_lf_from_fast |-> o_int_freq_sel == 3'h0; endproperty
  a_lf_code: assert property (p_lf_code)
    else $error("divided source used outside code zero");
  property p_fast_en; o_int_freq_sel != 3'h0 |-> o_fast_osc_en; endproperty
  a_fast_en: assert property (p_fast_en)
    else $error("fast oscillator off at a postscaler code");
  property p_mult;
    o_multiplier_en |-> o_int_freq_sel inside {3'h7, 3'h6};
  endproperty
  a_mult: assert property (p_mult)
    else $error("multiplier on at a low code");
  property p_idle_sleep; !(o_idle_mode && o_sleep_mode); endproperty
  a_idle_sleep: assert property (p_idle_sleep)
    else $error("idle and sleep both set");
  property p_answer; s_setup |=> o_pready && !$past(o_pready); endproperty
  a_answer: assert property (p_answer)
    else $error("no wait-free answer after setup");
  property p_err; o_pslverr |-> o_pready; endproperty
  a_err: assert property (p_err)
    else $error("error flag without ready");
endmodule // clk_source_switch_properties

/* File: clk_switch_pkg.sv */
// Purpose: Constants and types shared by the clock source switch design.
// Assumes: APB data 32 bits, one aligned word per register.
// Notes:   Offsets are byte addresses.
package clk_switch_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_OSC_CTRL   = 8'h00; // oscillator_control
  localparam logic [7:0] OFS_OSC_TUNE   = 8'h04; // oscillator_tuning
  localparam logic [7:0] OFS_TIMER_CTRL = 8'h08; // timer_one_control
  localparam logic [7:0] OFS_ACTIVE     = 8'h0c; // active source status
  // oscillator_control fields
  localparam int unsigned BIT_IDLE_EN  = 7;
  localparam int unsigned BIT_INTERNAL_FREQ_SELECT_LO  = 4;
  localparam int unsigned BIT_STARTUP_TIMEOUT_STATUS     = 3;
  localparam int unsigned BIT_INTERNAL_FREQ_STABLE     = 2;
  localparam int unsigned BIT_SCS_LO   = 0;
  // oscillator_tuning fields
  localparam int unsigned BIT_LF_SRC   = 7;
  localparam int unsigned BIT_MULT_EN  = 6;
  // timer_one_control fields
  localparam int unsigned BIT_SEC_RUN  = 6;
  localparam int unsigned BIT_SEC_EN   = 3;
  // Reset values
  localparam logic [2:0] INTERNAL_FREQ_SELECT_RESET    = 3'h4; // 1 MHz
  localparam logic [1:0] SCS_RESET     = 2'h0; // Primary
  localparam logic [4:0] TUNE_RESET    = 5'h00;
  // Frequency select codes
  localparam logic [2:0] INTERNAL_FREQ_SELECT_8MHZ     = 3'h7;
  localparam logic [2:0] INTERNAL_FREQ_SELECT_4MHZ     = 3'h6;
  localparam logic [2:0] INTERNAL_FREQ_SELECT_31KHZ    = 3'h0;
  // Glitch-free switch hold counts
  localparam logic [2:0] OLD_HOLD      = 3'h2;
  localparam logic [2:0] NEW_HOLD      = 3'h3;
  // Selected clock source
  typedef enum logic [2:0] {
    SRC_PRI  = 3'b001,
    SRC_SEC  = 3'b010,
    SRC_INT  = 3'b100
  } src_t;
  // Switch states
  typedef enum logic [3:0] {
    SW_RUN      = 4'b0001,
    SW_OLD_HOLD = 4'b0010,
    SW_NEW_HOLD = 4'b0100,
    SW_EXTRA    = 4'b1000
  } sw_state_t;
  // Decode of the two-bit system clock select
  function automatic src_t decode_scs(input logic [1:0] system_clock_select);
    if (system_clock_select[1])
      return SRC_INT;
    else if (system_clock_select[0])
      return SRC_SEC;
    else
      return SRC_PRI;
  endfunction
endpackage

/* File: clk_switch_seq.sv */
// Purpose: Glitch-free hold sequencer for a clock source change.
// Assumes: Tick inputs are synchronous single-cycle pulses.
// Notes:   Holds two old ticks then three or four new ticks.
`timescale 1ns/1ps
module clk_switch_seq
  import clk_switch_pkg::*;
(
  input  wire logic i_core_clk,
  input  wire logic i_sys_rst,
  clk_if.seq        sw
);
  sw_state_t state_q;          // Sequencer state
  logic [2:0] cnt_q;           // Ticks seen in this phase
  logic       done_q;          // Completion pulse
  wire        old_last = sw.old_tick && (cnt_q == OLD_HOLD - 3'h1);
  wire        new_last = sw.new_tick && (cnt_q == NEW_HOLD - 3'h1);

  assign sw.busy = (state_q != SW_RUN);
  assign sw.done = done_q;

  // Two old cycles, then three new ones, then an optional fourth
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state_q <= SW_RUN;
      cnt_q   <= 3'h0;
      done_q  <= 1'b0;
    end else begin
      done_q <= 1'b0;
      unique case (state_q)
        SW_RUN: begin
          cnt_q <= 3'h0;
          if (sw.start) state_q <= SW_OLD_HOLD;
        end
        SW_OLD_HOLD: begin
          if (old_last) begin
            state_q <= SW_NEW_HOLD;
            cnt_q   <= 3'h0;
          end else if (sw.old_tick) cnt_q <= cnt_q + 3'h1;
        end
        SW_NEW_HOLD: begin
          if (new_last) begin
            state_q <= sw.extra ? SW_EXTRA : SW_RUN;
            done_q  <= !sw.extra;
          end else if (sw.new_tick) cnt_q <= cnt_q + 3'h1;
        end
        SW_EXTRA: begin
          if (sw.new_tick) begin
            state_q <= SW_RUN;
            done_q  <= 1'b1;
          end
        end
        default: state_q <= SW_RUN;
      endcase
    end
  end
endmodule // clk_switch_seq
